// File: hdl/sup_pkg.sv
// constants, types and timing figures shared by the supervisor block
// assumes a 125 MHz system clock; link timing is set by the host's serial clock
package sup_pkg;

   // system clock rate in kHz, so that millisecond products stay inside 32 bits
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned CLK_PERIOD_NS = 8;

   // times as printed
   localparam int unsigned PWRUP_HOLD_MS = 200;
   localparam int unsigned RST_TIMEOUT_MS = 200;
   localparam int unsigned WDOG_LONG_MS = 1400;
   localparam int unsigned WDOG_MID_MS = 600;
   localparam int unsigned WDOG_SHORT_MS = 200;
   localparam int unsigned WRITE_CYCLE_MS = 10;
   localparam int unsigned KICK_WIDTH_NS = 400;

   // derived cycle counts: least times round up, longest times round down
   localparam int unsigned PWRUP_HOLD_CYC = PWRUP_HOLD_MS * CLK_KHZ;
   localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * CLK_KHZ;
   localparam int unsigned WDOG_LONG_CYC = WDOG_LONG_MS * CLK_KHZ;
   localparam int unsigned WDOG_MID_CYC = WDOG_MID_MS * CLK_KHZ;
   localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_MS * CLK_KHZ;
   localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * CLK_KHZ;
   localparam logic [5:0] KICK_CYC = 6'((KICK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam int TMR_W = 28;

   // serial instruction codes
   localparam logic [7:0] OP_SET_FLAG = 8'h00;
   localparam logic [7:0] OP_WR_STATUS = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_RD_DATA = 8'h03;
   localparam logic [7:0] OP_CLR_PERMIT = 8'h04;
   localparam logic [7:0] OP_RD_STATUS = 8'h05;
   localparam logic [7:0] OP_SET_PERMIT = 8'h06;

   // clock counts at which a frame may end
   localparam logic [8:0] BITS_OPCODE = 9'h008;
   localparam logic [8:0] BITS_STATUS_WR = 9'h010;
   localparam logic [8:0] BITS_WRITE_MIN = 9'h020;
   localparam logic [8:0] BITS_WRITE_MAX = 9'h118;
   localparam logic [8:0] BITS_SAT = 9'h1ff;

   // watchdog period selection codes
   localparam logic [1:0] WD_SEL_LONG = 2'h0;
   localparam logic [1:0] WD_SEL_MID = 2'h1;
   localparam logic [1:0] WD_SEL_SHORT = 2'h2;
   localparam logic [1:0] WD_SEL_OFF = 2'h3;

   // nonvolatile configuration held in the status byte
   typedef struct packed {
      logic wpen;
      logic watchdog_period_sel_hi;
      logic watchdog_period_sel_lo;
      logic [1:0] block_protect;
   } nv_cfg_t;

   localparam nv_cfg_t NV_CFG_RST = 5'h00;

   // status byte as shifted out, msb first
   typedef struct packed {
      logic wpen;
      logic user_flag_bit;
      logic [1:0] wd_sel;
      logic [1:0] block_protect;
      logic write_permit_latch;
      logic write_busy;
   } status_t;

   // synchronised pin levels
   typedef struct packed {
      logic cs_n;
      logic supply_low;
      logic wp_n;
   } pins_t;

   localparam pins_t PINS_RST = 3'h5;

   typedef enum logic [1:0] {
      ST_POWERUP = 2'b00,
      ST_RUN = 2'b01,
      ST_HOLD = 2'b11,
      ST_LOW = 2'b10
   } sup_state_t;

endpackage

// File: hdl/sync2.sv
// two-flop level synchroniser for a packed group of pin levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sync2 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire sup_pkg::pins_t d_i,
   output sup_pkg::pins_t q_o
);
   import sup_pkg::*;

   pins_t meta_q;
   pins_t sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= PINS_RST;
         sync_q <= PINS_RST;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule // sync2
`default_nettype wire

// File: hdl/supervisor_reset_and_powerup_state.sv
// supervisor reset, watchdog and power-up state of a serial memory companion
// assumes a host spi master drives sck, cs_n and si; reset pin is open drain with pull-up
// Overview of operation
// - low variant: reset low on brown-out or timeout
// - high variant: reset high on same causes
// - power up idle until host selects device
// - instructions only after a chip-select falling edge
// - serial output released at power-up
// - write permit latch cleared at power-up
// - user flag cleared at power-up
// - reset held for power-up interval
// - writes ignored unless write permit set first
// - write starts only on correct bit boundary
// - period select: 1.4 s, 600 ms, 200 ms, off
// - chip-select pulse restarts watchdog, min 400 ns
// - power-up hold between 100 and 280 ms
`timescale 1ns/100ps
`default_nettype none
module supervisor_reset_and_powerup_state #(
   parameter bit ACTIVE_HIGH = 1'b0,
   parameter int unsigned PWRUP_HOLD = sup_pkg::PWRUP_HOLD_CYC,
   parameter int unsigned RST_TIMEOUT = sup_pkg::RST_TIMEOUT_CYC,
   parameter int unsigned WDOG_LONG = sup_pkg::WDOG_LONG_CYC,
   parameter int unsigned WDOG_MID = sup_pkg::WDOG_MID_CYC,
   parameter int unsigned WDOG_SHORT = sup_pkg::WDOG_SHORT_CYC,
   parameter int unsigned WRITE_CYCLE = sup_pkg::WRITE_CYCLE_CYC
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   input wire logic supply_low_i,
   output logic so_o,
   output logic so_oe_o,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   output logic standby_o,
   output logic write_permit_latch_o,
   output logic user_flag_bit_o,
   output logic write_busy_o,
   output logic nv_write_start_o,
   output sup_pkg::nv_cfg_t nv_cfg_o
);
   import sup_pkg::*;

   // ---------------- link domain (sck) ----------------
   logic [8:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] opcode_q;
   logic [7:0] so_shift_q;
   logic so_q;
   logic so_oe_q;
   logic link_clr_q;
   status_t status_q;

   wire [7:0] shift_next = {shift_q[6:0], si_i};
   wire bit_cnt_sat = (bit_cnt_q == BITS_SAT);

   // cleared from the system side between frames; released only once cs
   // has fallen, well before the first sck edge, so counts stay valid
   // for the system side to read after cs rises
   always_ff @(posedge sck_i or posedge link_clr_q) begin
      if (link_clr_q) begin
         bit_cnt_q <= 9'h000;
      end else if (!bit_cnt_sat) begin
         bit_cnt_q <= bit_cnt_q + 9'h001;
      end
   end

   always_ff @(posedge sck_i) begin
      shift_q <= shift_next;
      if (bit_cnt_q == BITS_OPCODE - 9'h001) begin
         opcode_q <= shift_next;
      end
   end

   // status is sampled once per read; its bits change only between frames
   // except the busy bit, which may lag one read
   wire so_load = (bit_cnt_q == BITS_OPCODE) && (opcode_q == OP_RD_STATUS);

   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         so_oe_q <= 1'b0;
         so_q <= 1'b0;
         so_shift_q <= 8'h00;
      end else if (so_load) begin
         so_oe_q <= 1'b1;
         so_q <= status_q[7];
         so_shift_q <= {status_q[6:0], status_q[7]};
      end else if (so_oe_q) begin
         so_q <= so_shift_q[7];
         so_shift_q <= {so_shift_q[6:0], so_shift_q[7]};
      end
   end

   assign so_o = so_q;
   assign so_oe_o = so_oe_q;

   // ---------------- system domain ----------------
   pins_t pins_raw;
   pins_t pins_s;
   logic cs_n_dly_q;
   logic armed_q;
   logic [5:0] cs_low_cnt_q;
   sup_state_t state_q;
   sup_state_t state_d;
   logic [TMR_W-1:0] hold_cnt_q;
   logic [TMR_W-1:0] hold_cnt_d;
   logic [TMR_W-1:0] wd_cnt_q;
   logic [TMR_W-1:0] wc_cnt_q;
   logic wel_q;
   logic flag_q;
   nv_cfg_t nv_cfg_q;
   logic nv_start_q;
   logic rst_oe_q;
   logic rst_pin_q;
   logic standby_q;

   assign pins_raw = '{cs_n: cs_n_i, supply_low: supply_low_i, wp_n: wp_n_i};

   sync2 u_sync (
      .clk_i(ref_clk_i),
      .rst_i(sys_rst_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   wire cs_fall = cs_n_dly_q && !pins_s.cs_n;
   wire cs_rise = !cs_n_dly_q && pins_s.cs_n;
   wire supply_low = pins_s.supply_low;
   wire write_busy = (wc_cnt_q != '0);

   // watchdog restart needs cs held low for the minimum kick width
   wire wd_kick = !pins_s.cs_n && (cs_low_cnt_q == KICK_CYC - 6'h01);

   // frame decode on the cs rising edge
   wire [1:0] wd_sel = {nv_cfg_q.watchdog_period_sel_hi, nv_cfg_q.watchdog_period_sel_lo};
   wire frame_ok = cs_rise && armed_q && !write_busy;
   wire len_opcode = (bit_cnt_q == BITS_OPCODE);
   wire cfg_locked = nv_cfg_q.wpen && !pins_s.wp_n;
   wire do_set_permit = frame_ok && len_opcode && (opcode_q == OP_SET_PERMIT);
   wire do_clr_permit = frame_ok && len_opcode && (opcode_q == OP_CLR_PERMIT);
   wire do_set_flag = frame_ok && len_opcode && (opcode_q == OP_SET_FLAG);
   wire do_wr_status = frame_ok && wel_q && !cfg_locked
      && (opcode_q == OP_WR_STATUS) && (bit_cnt_q == BITS_STATUS_WR);
   wire write_len_ok = (bit_cnt_q >= BITS_WRITE_MIN) && (bit_cnt_q <= BITS_WRITE_MAX)
      && (bit_cnt_q[2:0] == 3'h0);
   wire do_wr_array = frame_ok && wel_q && (opcode_q == OP_WRITE) && write_len_ok;
   wire nv_start = do_wr_status || do_wr_array;

   // watchdog limit per period selection
   wire [TMR_W-1:0] wd_limit = (wd_sel == WD_SEL_LONG) ? TMR_W'(WDOG_LONG) :
      (wd_sel == WD_SEL_MID) ? TMR_W'(WDOG_MID) : TMR_W'(WDOG_SHORT);
   wire wd_enabled = (wd_sel != WD_SEL_OFF);
   wire wd_expire = wd_enabled && (wd_cnt_q == wd_limit - TMR_W'(1));
   wire hold_done = (hold_cnt_q == '0);

   always_comb begin
      state_d = state_q;
      hold_cnt_d = (hold_cnt_q != '0) ? hold_cnt_q - TMR_W'(1) : hold_cnt_q;
      case (state_q)
         ST_POWERUP: begin
            if (supply_low) begin
               state_d = ST_LOW;
            end else if (hold_done) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (supply_low) begin
               state_d = ST_LOW;
            end else if (wd_expire) begin
               state_d = ST_HOLD;
               hold_cnt_d = TMR_W'(RST_TIMEOUT);
            end
         end
         ST_LOW: begin
            if (!supply_low) begin
               state_d = ST_HOLD;
               hold_cnt_d = TMR_W'(RST_TIMEOUT);
            end
         end
         ST_HOLD: begin
            if (supply_low) begin
               state_d = ST_LOW;
            end else if (hold_done) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_POWERUP;
         end
      endcase
   end

   wire rst_assert_d = (state_d != ST_RUN);
   // open drain: the low variant pulls while asserted, the high variant
   // pulls while idle and releases so the pull-up shows the active level
   wire rst_pull_d = rst_assert_d ^ ACTIVE_HIGH;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_POWERUP;
         hold_cnt_q <= TMR_W'(PWRUP_HOLD);
         rst_oe_q <= ~ACTIVE_HIGH;
      end else begin
         state_q <= state_d;
         hold_cnt_q <= hold_cnt_d;
         rst_oe_q <= rst_pull_d;
      end
   end

   // watchdog count: cleared outside normal running, on a kick, or when off
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || state_q != ST_RUN || wd_kick || !wd_enabled) begin
         wd_cnt_q <= '0;
      end else begin
         wd_cnt_q <= wd_cnt_q + TMR_W'(1);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || pins_s.cs_n) begin
         cs_low_cnt_q <= 6'h00;
      end else if (cs_low_cnt_q != KICK_CYC) begin
         cs_low_cnt_q <= cs_low_cnt_q + 6'h01;
      end
   end

   // frame bookkeeping and link counter clear
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cs_n_dly_q <= 1'b1;
         armed_q <= 1'b0;
         link_clr_q <= 1'b1;
         standby_q <= 1'b1;
      end else begin
         cs_n_dly_q <= pins_s.cs_n;
         if (cs_fall) begin
            armed_q <= 1'b1;
         end
         link_clr_q <= cs_n_dly_q && pins_s.cs_n;
         standby_q <= pins_s.cs_n || !armed_q;
      end
   end

   // volatile latches and nonvolatile configuration
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wel_q <= 1'b0;
         flag_q <= 1'b0;
         nv_cfg_q <= NV_CFG_RST;
         nv_start_q <= 1'b0;
         wc_cnt_q <= '0;
      end else begin
         nv_start_q <= nv_start;
         if (do_set_permit) begin
            wel_q <= 1'b1;
         end else if (do_clr_permit || nv_start) begin
            wel_q <= 1'b0;
         end
         if (do_set_flag) begin
            flag_q <= 1'b1;
         end else if (do_clr_permit) begin
            flag_q <= 1'b0;
         end else if (do_wr_status) begin
            flag_q <= shift_q[6];
         end
         if (do_wr_status) begin
            nv_cfg_q <= '{wpen: shift_q[7], watchdog_period_sel_hi: shift_q[5],
               watchdog_period_sel_lo: shift_q[4], block_protect: shift_q[3:2]};
         end
         if (nv_start) begin
            wc_cnt_q <= TMR_W'(WRITE_CYCLE);
         end else if (write_busy) begin
            wc_cnt_q <= wc_cnt_q - TMR_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         status_q <= '0;
         rst_pin_q <= 1'b0;
      end else begin
         status_q <= '{wpen: nv_cfg_q.wpen, user_flag_bit: flag_q, wd_sel: wd_sel,
            block_protect: nv_cfg_q.block_protect, write_permit_latch: wel_q,
            write_busy: write_busy};
         rst_pin_q <= 1'b0;
      end
   end

   assign rst_pin_o = rst_pin_q;
   assign rst_pin_oe_o = rst_oe_q;
   assign standby_o = standby_q;
   assign write_permit_latch_o = status_q.write_permit_latch;
   assign user_flag_bit_o = status_q.user_flag_bit;
   assign write_busy_o = status_q.write_busy;
   assign nv_write_start_o = nv_start_q;
   assign nv_cfg_o = nv_cfg_q;

endmodule // supervisor_reset_and_powerup_state
`default_nettype wire

// File: tb/supervisor_sva.sv
// assertions on the supervisor pins, bound into the design top
// assumes the low-asserting variant: a driven reset pin means reset asserted
`timescale 1ns/100ps
`default_nettype none
module supervisor_sva #(
   parameter int unsigned PWRUP_HOLD = 200
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n_i,
   input wire logic supply_low_i,
   input wire logic so_oe_o,
   input wire logic rst_pin_oe_o,
   input wire logic standby_o,
   input wire logic write_permit_latch_o,
   input wire logic user_flag_bit_o,
   input wire logic write_busy_o,
   input wire logic nv_write_start_o
);
   logic [15:0] up_q;
   logic [15:0] up_d;
   // saturates so the power-up window is never seen twice
   assign up_d = (up_q == 16'hffff) ? up_q : up_q + 16'h0001;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) up_q <= 16'h0000;
      else up_q <= up_d;
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   a_supply_reset: assert property (supply_low_i [*4] |-> rst_pin_oe_o)
      else $error("reset not asserted on low supply");
   a_supply_hold: assert property ($fell(supply_low_i) |-> rst_pin_oe_o [*8])
      else $error("reset dropped right after supply recovered");
   a_hold_powerup: assert property (up_q < PWRUP_HOLD - 1 |-> rst_pin_oe_o)
      else $error("power-up reset released early");
   a_release_powerup: assert property (up_q == PWRUP_HOLD |-> ##[1:8] !rst_pin_oe_o)
      else $error("power-up reset never released");
   a_powerup_state: assert property ($fell(sys_rst_i) |->
      standby_o && !write_permit_latch_o && !user_flag_bit_o && !write_busy_o)
      else $error("power-up state wrong");
   a_so_released: assert property (cs_n_i [*2] |-> !so_oe_o)
      else $error("serial output driven while deselected");
   a_standby_idle: assert property (cs_n_i [*6] |-> standby_o)
      else $error("not in standby while deselected");
   a_permit_gate: assert property ($rose(nv_write_start_o) |-> $past(write_permit_latch_o))
      else $error("write started without permit");
   a_start_pulse: assert property (nv_write_start_o |=> !nv_write_start_o ##[0:2] write_busy_o)
      else $error("write start not a single pulse followed by busy");
   a_start_after_cs: assert property (nv_write_start_o |-> cs_n_i && $past(cs_n_i, 2))
      else $error("write started while selected");
   cover property (nv_write_start_o);
   cover property ($rose(rst_pin_oe_o));
   cover property ($fell(standby_o));
endmodule // supervisor_sva
bind supervisor_reset_and_powerup_state supervisor_sva #(.PWRUP_HOLD(PWRUP_HOLD)) supervisor_sva_inst (.*);
`default_nettype wire

// File: tb/host_model.sv
// host master on the serial link; clock runs only inside frames
// assumes the bench calls its tasks one at a time
`timescale 1ns/100ps
`default_nettype none
module host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   logic [7:0] rd_q;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      rd_q = 8'h00;
   end
   // deselect gap first, then a fresh select fall, close 256 ns after the last bit
   task automatic xfer(input logic [39:0] d, input int n);
      #512 cs_n_o = 1'b0;
      #256;
      for (int i = n - 1; i >= 0; i--) begin
         si_o = d[i];
         #3;
         if (so_oe_i === 1'b1) rd_q = {rd_q[6:0], so_i};
         sck_o = 1'b1;
         #3 sck_o = 1'b0;
         si_o = ~d[i];
      end
      #256 cs_n_o = 1'b1;
   endtask
   // select with no clocks, long enough to restart the watchdog
   task automatic kick();
      #512 cs_n_o = 1'b0;
      #480 cs_n_o = 1'b1;
   endtask
endmodule // host_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the supervisor block with a host model on the link
// assumes short timing parameters so each long figure becomes at most 1400 cycles
`timescale 1ns/100ps
`default_nettype none
module tb;
   import sup_pkg::*;
   logic ref_clk_i, sys_rst_i, sck_i, cs_n_i, si_i, wp_n_i, supply_low_i;
   logic so_o, so_oe_o, rst_pin_o, rst_pin_oe_o, standby_o;
   logic write_permit_latch_o, user_flag_bit_o, write_busy_o, nv_write_start_o;
   nv_cfg_t nv_cfg_o, c;
   logic p, f;
   logic [7:0] er;
   logic [17:0] act_v, exp_v;
   logic [17:0] exp_q[$];
   logic [31:0] r;
   int fails, compares;
   // short timing so each long figure takes at most 1400 cycles
   localparam int HOLD_CYC = 200;
   localparam int TIMEOUT_CYC = 100;
   localparam int WD_LONG_CYC = 1400;
   localparam int WD_MID_CYC = 600;
   localparam int WD_SHORT_CYC = 300;
   localparam int WC_CYC = 50;
   int lim[4] = '{WD_LONG_CYC, WD_MID_CYC, WD_SHORT_CYC, WD_LONG_CYC};
   event obs;
   supervisor_reset_and_powerup_state #(.PWRUP_HOLD(HOLD_CYC), .RST_TIMEOUT(TIMEOUT_CYC),
      .WDOG_LONG(WD_LONG_CYC), .WDOG_MID(WD_MID_CYC), .WDOG_SHORT(WD_SHORT_CYC), .WRITE_CYCLE(WC_CYC))
      supervisor_reset_and_powerup_state_inst (.*);
   host_model host_model_inst (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_i(so_oe_o));
   assign act_v = {rst_pin_oe_o, standby_o, write_permit_latch_o, user_flag_bit_o, write_busy_o,
      nv_cfg_o, host_model_inst.rd_q};
   initial ref_clk_i = 1'b0;
   always #4 ref_clk_i = ~ref_clk_i;
   task automatic print_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic note(input logic rs, input logic b);
      exp_q.push_back({rs, 1'b1, p, f, b, c, er});
      -> obs;
   endtask
   task automatic send(input logic [39:0] d, input int n);
      host_model_inst.xfer(d, n);
      cyc(8);
   endtask
   task automatic wait_idle();
      int k;
      for (k = 0; k < 200 && write_busy_o !== 1'b0; k++) cyc(1);
      if (k == 200) begin
         fails++;
         print_verdict();
      end
   endtask
   // permit first, then the status byte; ok says whether it must be taken
   task automatic wr_status(input logic [7:0] v, input logic ok);
      send(40'h06, 8);
      send({24'h0, 8'h01, v}, 16);
      p = ~ok;
      if (ok) begin
         f = v[6];
         c = {v[7], v[5:2]};
      end
      note(1'b0, ok);
      wait_idle();
   endtask
   always @(obs) begin
      exp_v = exp_q.pop_front();
      compares++;
      if (act_v !== exp_v) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, act_v, exp_v);
      end
   end
   initial begin
      #300000;
      fails++;
      print_verdict();
   end
   initial begin
      {sys_rst_i, wp_n_i, supply_low_i} = 3'b110;
      {p, f, c, er} = '0;
      fails = 0;
      compares = 0;
      void'($urandom(20961));
      cyc(8);
      sys_rst_i = 1'b0;
      cyc(1);
      note(1'b1, 1'b0);
      cyc(HOLD_CYC - 10);
      note(1'b1, 1'b0);
      cyc(30);
      note(1'b0, 1'b0);
      $display("test power_up done");
      send(40'h00, 8);
      f = 1'b1;
      note(1'b0, 1'b0);
      send({24'h0, 8'h01, 8'h8c}, 16);
      note(1'b0, 1'b0);
      send(40'h04, 8);
      f = 1'b0;
      note(1'b0, 1'b0);
      send(40'h0c, 9);
      note(1'b0, 1'b0);
      $display("test refusals done");
      r = $urandom();
      wr_status({1'b0, r[0], 2'h1, r[2:1], 2'b00}, 1'b1);
      note(1'b0, 1'b0);
      send(40'h0500, 16);
      er = {c[4], f, c[3:0], p, 1'b0};
      note(1'b0, 1'b0);
      send(40'h06, 8);
      p = 1'b1;
      send({7'h0, 8'h02, 16'h0010, r[15:8], 1'b0}, 33);
      note(1'b0, 1'b0);
      send({8'h0, 8'h02, 16'h0010, r[15:8]}, 32);
      p = 1'b0;
      note(1'b0, 1'b1);
      wait_idle();
      send({8'h0, 8'h02, 16'h0020, r[23:16]}, 32);
      note(1'b0, 1'b0);
      $display("test writes done");
      wr_status({1'b1, f, 2'h1, c[1:0], 2'b00}, 1'b1);
      wp_n_i = 1'b0;
      wr_status({1'b0, ~f, 2'h1, ~c[1:0], 2'b00}, 1'b0);
      wp_n_i = 1'b1;
      cyc(4);
      wr_status({1'b0, f, 2'h1, c[1:0], 2'b00}, 1'b1);
      $display("test protect done");
      supply_low_i = 1'b1;
      cyc(5);
      note(1'b1, 1'b0);
      cyc(30);
      note(1'b1, 1'b0);
      supply_low_i = 1'b0;
      cyc(TIMEOUT_CYC - 10);
      note(1'b1, 1'b0);
      cyc(20);
      note(1'b0, 1'b0);
      $display("test supply done");
      for (int i = 0; i < 4; i++) begin
         wr_status({1'b0, f, i[1:0], c[1:0], 2'b00}, 1'b1);
         host_model_inst.kick();
         cyc(lim[i] - 40);
         note(1'b0, 1'b0);
         cyc(80);
         note(i < 3, 1'b0);
         cyc(120);
      end
      $display("test watchdog done");
      // permit set just before a second reset, which must clear it again
      send(40'h06, 8);
      p = 1'b1;
      note(1'b0, 1'b0);
      sys_rst_i = 1'b1;
      cyc(8);
      sys_rst_i = 1'b0;
      {p, f, c} = '0;
      cyc(1);
      note(1'b1, 1'b0);
      cyc(HOLD_CYC + 20);
      note(1'b0, 1'b0);
      $display("test restart done");
      print_verdict();
   end
endmodule // tb
`default_nettype wire
